// ### hw/sfs_consts.svh
// Offsets, reset values and timing constants of the fault-stop controller
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
// ======================================================
// Register byte offsets
`define SFS_OFF_GEN_MODE   8'h00
`define SFS_OFF_MINOR_MODE 8'h04
`define SFS_OFF_OT_MODE    8'h08
`define SFS_OFF_FAST_TIME  8'h0c
`define SFS_OFF_SLOW_TIME  8'h10
`define SFS_OFF_BRAKE_CUR  8'h14
`define SFS_OFF_RATED      8'h18
`define SFS_OFF_CTRL       8'h1c
`define SFS_OFF_STATUS     8'h20
`define SFS_OFF_IRQ_STS    8'h24
`define SFS_OFF_IRQ_MASK   8'h28
// ======================================================
// Field positions
`define SFS_CTRL_CLEAR     0
`define SFS_CTRL_SW_LIMIT  1
`define SFS_IRQ_SERIOUS    0
`define SFS_IRQ_GENERAL    1
`define SFS_IRQ_MINOR      2
`define SFS_IRQ_LIMIT      3
`define SFS_IRQ_DONE       4
// ======================================================
// Reset values
`define SFS_RST_MODE       16'h0000
`define SFS_RST_FAST_TIME  16'h01f4
`define SFS_RST_SLOW_TIME  16'h03e8
`define SFS_RST_BRAKE_CUR  16'h0000
`define SFS_RST_RATED      16'h0bb8
// ======================================================
// Fault code class bounds
`define SFS_CODE_SERIOUS_LO 10'd100
`define SFS_CODE_SERIOUS_HI 10'd199
`define SFS_CODE_GENERAL_LO 10'd200
`define SFS_CODE_GENERAL_HI 10'd599
`define SFS_CODE_MINOR_LO   10'd600
`define SFS_CODE_MINOR_HI   10'd999
// ======================================================
// Timing
`define SFS_CLK_PERIOD_NS  100
`define SFS_STOP_UNIT_NS   1000000
`define SFS_MS_CYCLES      (`SFS_STOP_UNIT_NS / `SFS_CLK_PERIOD_NS)
`endif

// ### hw/sfs_pkg.sv
// Types shared by the fault-stop controller
package sfs_pkg;
   typedef enum logic [2:0] {
      SFS_RUN   = 3'b000,
      SFS_RAMP  = 3'b001,
      SFS_BRAKE = 3'b010,
      SFS_HOLD  = 3'b011,
      SFS_OFF   = 3'b100
   } sfs_state_type;

   typedef enum logic [1:0] {
      SFS_CLS_NONE    = 2'b00,
      SFS_CLS_SERIOUS = 2'b01,
      SFS_CLS_GENERAL = 2'b10,
      SFS_CLS_MINOR   = 2'b11
   } sfs_class_type;
endpackage : sfs_pkg

// ### hw/sfs_top.sv
// Fault-stop controller: fault classing, stop mode selection, ramp and APB registers
`timescale 1ns/1ps
`include "sfs_consts.svh"

// Notes on behaviour
// - codes 100..199 remove motor power at once and let the motor coast.
// - codes 200..599 stop as the general-class stop mode says.
// - codes 600..999 stop as the minor-class stop mode says.
// - a hardware or software travel limit uses the over-travel stop mode.
// - free stop disconnects the drive output; only friction slows the motor.
// - during a ramp the motor stays energised and is driven toward zero.
// - ramp modes that end disabled drop drive and power at zero speed.
// - stay-enabled modes hold enabled; dropping the enable input disables.
// - fast ramps use the fast stop time, slow ramps the slow stop time.
// - stop time spans rated speed to zero, so duration scales with speed.
// - 2 slow then disable, 3 fast hold, 4 slow hold, 5 brake at set current.
module sfs_top import sfs_pkg::*; #(
   parameter int MS_CYCLES = `SFS_MS_CYCLES,
   parameter int CODE_W = 10,
   parameter int SPEED_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CODE_W-1:0] fault_code,
   input wire logic fault_valid,
   input wire logic limit_pin,
   input wire logic ext_enable_pin,
   input wire logic [SPEED_W-1:0] motor_speed,
   output logic drive_out_en,
   output logic motor_power_on,
   output logic brake_on,
   output logic [15:0] brake_current,
   output logic [SPEED_W-1:0] speed_cmd,
   output logic stop_active,
   output logic irq
);

   // ======================================================
   // Helpers
   function automatic sfs_class_type classify(input logic [CODE_W-1:0] code);
      if (code >= `SFS_CODE_SERIOUS_LO && code <= `SFS_CODE_SERIOUS_HI) begin
         return SFS_CLS_SERIOUS;
      end else if (code >= `SFS_CODE_GENERAL_LO && code <= `SFS_CODE_GENERAL_HI) begin
         return SFS_CLS_GENERAL;
      end else if (code >= `SFS_CODE_MINOR_LO && code <= `SFS_CODE_MINOR_HI) begin
         return SFS_CLS_MINOR;
      end
      return SFS_CLS_NONE;
   endfunction : classify

   // Out-of-range mode values fall back to free coast, the safest stop
   function automatic logic [2:0] mode_of(input logic [15:0] r);
      return (r > 16'h0005) ? 3'd0 : r[2:0];
   endfunction : mode_of

   // ======================================================
   // Pin synchronisers
   logic lim_s1_q, lim_s2_q, lim_prev_q, en_s1_q, en_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_s1_q <= 1'b0;
         lim_s2_q <= 1'b0;
         lim_prev_q <= 1'b0;
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
      end else begin
         lim_s1_q <= limit_pin;
         lim_s2_q <= lim_s1_q;
         lim_prev_q <= lim_s2_q;
         en_s1_q <= ext_enable_pin;
         en_s2_q <= en_s1_q;
      end
   end

   // ======================================================
   // Registers and APB slave
   logic [15:0] gen_q, gen_d, minor_q, minor_d, ot_q, ot_d;
   logic [15:0] fast_q, fast_d, slow_q, slow_d, bcur_q, bcur_d, rated_q, rated_d;
   logic [4:0] ists_q, ists_d, imask_q, imask_d, events;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic wr_acc, clear_req, sw_limit, mapped;
   sfs_state_type state_q, state_d;
   logic [2:0] rank_q;
   logic [SPEED_W-1:0] scmd_q;

   assign wr_acc = psel && penable && pready_q && pwrite;
   assign clear_req = wr_acc && paddr == `SFS_OFF_CTRL && pwdata[`SFS_CTRL_CLEAR];
   assign sw_limit = wr_acc && paddr == `SFS_OFF_CTRL && pwdata[`SFS_CTRL_SW_LIMIT];

   always_comb begin
      gen_d = gen_q;
      minor_d = minor_q;
      ot_d = ot_q;
      fast_d = fast_q;
      slow_d = slow_q;
      bcur_d = bcur_q;
      rated_d = rated_q;
      imask_d = imask_q;
      ists_d = ists_q | events;
      mapped = 1'b1;
      prdata_d = prdata_q;
      // Answer one cycle after setup: pready rises in the first access cycle
      pready_d = psel && !penable;
      pslverr_d = 1'b0;
      if (wr_acc) begin
         unique case (paddr)
            `SFS_OFF_GEN_MODE: gen_d = pwdata[15:0];
            `SFS_OFF_MINOR_MODE: minor_d = pwdata[15:0];
            `SFS_OFF_OT_MODE: ot_d = pwdata[15:0];
            `SFS_OFF_FAST_TIME: fast_d = pwdata[15:0];
            `SFS_OFF_SLOW_TIME: slow_d = pwdata[15:0];
            `SFS_OFF_BRAKE_CUR: bcur_d = pwdata[15:0];
            `SFS_OFF_RATED: rated_d = pwdata[15:0];
            // Set wins over clear when an event lands in the clearing cycle
            `SFS_OFF_IRQ_STS: ists_d = (ists_q & ~pwdata[4:0]) | events;
            `SFS_OFF_IRQ_MASK: imask_d = pwdata[4:0];
            default: ;
         endcase
      end
      if (psel && !penable) begin
         unique case (paddr)
            `SFS_OFF_GEN_MODE: prdata_d = {16'h0000, gen_q};
            `SFS_OFF_MINOR_MODE: prdata_d = {16'h0000, minor_q};
            `SFS_OFF_OT_MODE: prdata_d = {16'h0000, ot_q};
            `SFS_OFF_FAST_TIME: prdata_d = {16'h0000, fast_q};
            `SFS_OFF_SLOW_TIME: prdata_d = {16'h0000, slow_q};
            `SFS_OFF_BRAKE_CUR: prdata_d = {16'h0000, bcur_q};
            `SFS_OFF_RATED: prdata_d = {16'h0000, rated_q};
            `SFS_OFF_CTRL: prdata_d = 32'h0000_0000;
            `SFS_OFF_STATUS: prdata_d = {23'h000000, en_s2_q, lim_s2_q, 1'b0, rank_q, state_q};
            `SFS_OFF_IRQ_STS: prdata_d = {27'h0000000, ists_q};
            `SFS_OFF_IRQ_MASK: prdata_d = {27'h0000000, imask_q};
            default: mapped = 1'b0;
         endcase
         if (!mapped) begin
            prdata_d = 32'h0000_0000;
         end
         pslverr_d = !mapped;
      end
      irq_d = |(ists_d & imask_d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_q <= `SFS_RST_MODE;
         minor_q <= `SFS_RST_MODE;
         ot_q <= `SFS_RST_MODE;
         fast_q <= `SFS_RST_FAST_TIME;
         slow_q <= `SFS_RST_SLOW_TIME;
         bcur_q <= `SFS_RST_BRAKE_CUR;
         rated_q <= `SFS_RST_RATED;
         ists_q <= 5'h00;
         imask_q <= 5'h00;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         gen_q <= gen_d;
         minor_q <= minor_d;
         ot_q <= ot_d;
         fast_q <= fast_d;
         slow_q <= slow_d;
         bcur_q <= bcur_d;
         rated_q <= rated_d;
         ists_q <= ists_d;
         imask_q <= imask_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   // ======================================================
   // Stop sequencer
   logic [15:0] time_q, time_d;
   logic keep_q, keep_d;
   logic [31:0] acc_q, acc_d, thr, acc_sum;
   logic [SPEED_W-1:0] scmd_d;
   logic [2:0] rank_d, ev_rank, ev_mode;
   logic drive_q, drive_d, power_q, power_d, brake_q, brake_d, stop_q, stop_d;
   sfs_class_type cls;

   assign cls = fault_valid ? classify(fault_code) : SFS_CLS_NONE;
   assign thr = 32'(time_q) * 32'(MS_CYCLES);
   assign acc_sum = acc_q + 32'(rated_q);

   always_comb begin
      // Severity ranks: serious 4, general 3, over-travel 2, minor 1
      ev_rank = 3'd0;
      ev_mode = 3'd0;
      events = 5'h00;
      if (cls == SFS_CLS_MINOR) begin
         ev_rank = 3'd1;
         ev_mode = mode_of(minor_q);
         events[`SFS_IRQ_MINOR] = 1'b1;
      end
      if ((lim_s2_q && !lim_prev_q) || sw_limit) begin
         ev_rank = 3'd2;
         ev_mode = mode_of(ot_q);
         events[`SFS_IRQ_LIMIT] = 1'b1;
      end
      if (cls == SFS_CLS_GENERAL) begin
         ev_rank = 3'd3;
         ev_mode = mode_of(gen_q);
         events[`SFS_IRQ_GENERAL] = 1'b1;
      end
      if (cls == SFS_CLS_SERIOUS) begin
         ev_rank = 3'd4;
         ev_mode = 3'd0;
         events[`SFS_IRQ_SERIOUS] = 1'b1;
      end
      state_d = state_q;
      rank_d = rank_q;
      time_d = time_q;
      keep_d = keep_q;
      acc_d = acc_q;
      scmd_d = scmd_q;
      unique case (state_q)
         SFS_RUN: scmd_d = '0;
         SFS_RAMP: begin
            // Bresenham step: rated speed to zero takes exactly time_q ms
            if (acc_sum >= thr) begin
               acc_d = acc_sum - thr;
               scmd_d = (scmd_q == '0) ? scmd_q : scmd_q - SPEED_W'(1);
            end else begin
               acc_d = acc_sum;
            end
            if (scmd_q == '0) begin
               state_d = keep_q ? SFS_HOLD : SFS_OFF;
               events[`SFS_IRQ_DONE] = 1'b1;
            end
         end
         SFS_BRAKE: begin
            if (motor_speed == '0) begin
               state_d = SFS_OFF;
               events[`SFS_IRQ_DONE] = 1'b1;
            end
         end
         SFS_HOLD: begin
            if (!en_s2_q) begin
               state_d = SFS_OFF;
            end
         end
         SFS_OFF: ;
      endcase
      if ((state_q == SFS_OFF || state_q == SFS_HOLD) && clear_req && ev_rank == 3'd0) begin
         state_d = SFS_RUN;
         rank_d = 3'd0;
      end
      // A new event only takes over when it is more severe than the current one
      if (ev_rank > rank_q) begin
         rank_d = ev_rank;
         acc_d = 32'h0000_0000;
         keep_d = (ev_mode == 3'd3) || (ev_mode == 3'd4);
         time_d = (ev_mode == 3'd1 || ev_mode == 3'd3) ? fast_q : slow_q;
         if (state_q != SFS_RAMP) begin
            scmd_d = motor_speed;
         end
         unique case (ev_mode)
            3'd0: state_d = SFS_OFF;
            3'd5: state_d = SFS_BRAKE;
            default: state_d = SFS_RAMP;
         endcase
      end
      drive_d = (state_d == SFS_RUN) ? en_s2_q : (state_d != SFS_OFF);
      power_d = (state_d != SFS_OFF);
      brake_d = (state_d == SFS_BRAKE);
      stop_d = (rank_d != 3'd0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SFS_RUN;
         rank_q <= 3'd0;
         time_q <= `SFS_RST_SLOW_TIME;
         keep_q <= 1'b0;
         acc_q <= 32'h0000_0000;
         scmd_q <= '0;
         drive_q <= 1'b0;
         power_q <= 1'b0;
         brake_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         state_q <= state_d;
         rank_q <= rank_d;
         time_q <= time_d;
         keep_q <= keep_d;
         acc_q <= acc_d;
         scmd_q <= scmd_d;
         drive_q <= drive_d;
         power_q <= power_d;
         brake_q <= brake_d;
         stop_q <= stop_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign drive_out_en = drive_q;
   assign motor_power_on = power_q;
   assign brake_on = brake_q;
   assign brake_current = bcur_q;
   assign speed_cmd = scmd_q;
   assign stop_active = stop_q;

   // ======================================================
   // Assertions
   a_serious_coast: assert property (@(posedge pclk) disable iff (!presetn)
      fault_valid && classify(fault_code) == SFS_CLS_SERIOUS |=> !drive_q && !power_q)
      else $error("serious fault did not cut power");
   a_general_mode: assert property (@(posedge pclk) disable iff (!presetn)
      cls == SFS_CLS_GENERAL && rank_q < 3'd3 && mode_of(gen_q) == 3'd0 |=> state_q == SFS_OFF)
      else $error("general fault ignored its stop mode");
   a_minor_mode: assert property (@(posedge pclk) disable iff (!presetn)
      ev_rank == 3'd1 && rank_q == 3'd0 && mode_of(minor_q) == 3'd5 |=> state_q == SFS_BRAKE)
      else $error("minor fault ignored its stop mode");
   a_limit_rank: assert property (@(posedge pclk) disable iff (!presetn)
      sw_limit && ev_rank == 3'd2 && rank_q < 3'd2 |=> rank_q == 3'd2)
      else $error("travel limit not taken");
   a_ramp_powered: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == SFS_RAMP |-> drive_q && power_q)
      else $error("ramp without energised motor");
   a_ramp_end_off: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == SFS_RAMP && scmd_q == '0 && !keep_q && ev_rank <= rank_q
      |=> state_q == SFS_OFF ##1 !power_q)
      else $error("ramp end did not disable");
   a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == SFS_HOLD && !en_s2_q && ev_rank <= rank_q |=> ##1 !drive_q)
      else $error("hold did not drop on enable loss");
   a_ramp_time: assert property (@(posedge pclk) disable iff (!presetn)
      ev_rank > rank_q && ev_mode == 3'd1 |=> time_q == $past(fast_q))
      else $error("fast stop time not used");
   a_severity: assert property (@(posedge pclk) disable iff (!presetn)
      rank_q == 3'd4 |=> rank_q == 3'd4 || $past(clear_req))
      else $error("severity dropped without clear");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq_q == |($past(ists_d) & $past(imask_d)))
      else $error("interrupt level mismatch");

endmodule : sfs_top

// ### verification/sfs_motor_model.sv
// Partner model: motor power stage with friction and the external enable switch
`timescale 1ns/1ps
module sfs_motor_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic drive_out_en,
   input wire logic motor_power_on,
   input wire logic brake_on,
   input wire logic stop_active,
   input wire logic [15:0] speed_cmd,
   input wire logic [15:0] run_speed,
   input wire logic en_req,
   output logic [15:0] motor_speed,
   output logic ext_enable_pin
);
   // ==========================================
   // Rotor speed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_speed <= 16'h0000;
      end else if (!stop_active) begin
         motor_speed <= run_speed;
      end else if (drive_out_en && motor_power_on && !brake_on) begin
         motor_speed <= speed_cmd;
      end else if (motor_speed != 16'h0000) begin
         // Unpowered rotor only slows by friction or brake current
         motor_speed <= motor_speed - 16'h0001;
      end
   end
   // Operator releases a held stop by dropping the enable input
   assign ext_enable_pin = en_req;
endmodule : sfs_motor_model

// ### verification/sfs_top_tb_top.sv
// Self-checking bench of the fault-stop controller
`timescale 1ns/1ps
`include "sfs_consts.svh"
module sfs_top_tb_top;
   import sfs_pkg::*;
   localparam int MS = 10;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_valid, limit_pin, irq;
   logic ext_enable_pin, drive_out_en, motor_power_on, brake_on, stop_active, en_req, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] fault_code;
   logic [15:0] motor_speed, speed_cmd, brake_current, run_speed;
   int failures, n_tests, seed, n, spd, tm, expc, bad;
   int offs[7] = '{0, 4, 8, 12, 16, 20, 24};
   int rsts[7] = '{0, 0, 0, 500, 1000, 0, 3000};
   int codes[4] = '{100, 199, 150, 0};

   sfs_top #(.MS_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fault_code(fault_code), .fault_valid(fault_valid),
      .limit_pin(limit_pin), .ext_enable_pin(ext_enable_pin), .motor_speed(motor_speed),
      .drive_out_en(drive_out_en), .motor_power_on(motor_power_on), .brake_on(brake_on),
      .brake_current(brake_current), .speed_cmd(speed_cmd), .stop_active(stop_active),
      .irq(irq));
   sfs_motor_model motor (.pclk(pclk), .presetn(presetn), .drive_out_en(drive_out_en),
      .motor_power_on(motor_power_on), .brake_on(brake_on), .stop_active(stop_active),
      .speed_cmd(speed_cmd), .run_speed(run_speed), .en_req(en_req),
      .motor_speed(motor_speed), .ext_enable_pin(ext_enable_pin));

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic edges(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask : edges

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Slave latency is not assumed: only the watchdog ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse(input logic [9:0] c);
      @(posedge pclk);
      fault_valid <= 1'b1;
      fault_code <= c;
      @(posedge pclk);
      fault_valid <= 1'b0;
   endtask : pulse

   task automatic wait_stop();
      n = 0;
      while (stop_active !== 1'b1 && n < 8) begin
         edges(1);
         n++;
      end
   endtask : wait_stop

   task automatic clear_stop();
      @(posedge pclk);
      limit_pin <= 1'b0;
      en_req <= 1'b1;
      apb(`SFS_OFF_IRQ_STS, 1'b1, 32'h1f);
      apb(`SFS_OFF_CTRL, 1'b1, 32'h1);
      n = 0;
      while (drive_out_en !== 1'b1 && n < 10) begin
         edges(1);
         n++;
      end
      chk(stop_active, 1'b0);
   endtask : clear_stop

   // c: 1 general, 2 minor, 3 travel limit; m: stop mode under test
   task automatic run_stop(input int c, input int m);
      spd = 16 + ({$random(seed)} % 16);
      run_speed <= spd[15:0];
      apb(8'((c - 1) * 4), 1'b1, 32'(m));
      apb(`SFS_OFF_BRAKE_CUR, 1'b1, 32'(spd + m));
      edges(3);
      if (c == 3 && m % 2 == 1) apb(`SFS_OFF_CTRL, 1'b1, 32'h2);
      else if (c == 3) begin
         @(posedge pclk);
         limit_pin <= 1'b1;
      end else pulse(10'(c * 400 - 200 + {$random(seed)} % 400));
      wait_stop();
      chk(stop_active, 1'b1);
      if (m == 0) begin
         edges(1);
         chk({drive_out_en, motor_power_on}, 2'b00);
      end else if (m == 5) begin
         chk({brake_on, brake_current}, {1'b1, 16'(spd + m)});
         n = 0;
         while (brake_on === 1'b1 && n < 100) begin
            edges(1);
            n++;
         end
         edges(3);
         chk({brake_on, drive_out_en, motor_power_on}, 3'b000);
      end else begin
         tm = (m == 1 || m == 3) ? 3 : 6;
         expc = spd * tm * MS / 10;
         n = 0;
         bad = 0;
         while (speed_cmd !== 16'h0000 && n < 1000) begin
            edges(1);
            n++;
            if ({drive_out_en, motor_power_on} !== 2'b11 && speed_cmd !== 16'h0) bad++;
         end
         chk(bad, 0);
         chk(n >= expc - expc / 4 - 4 && n <= expc + expc / 4 + 4, 1'b1);
         if (m < 3) begin
            edges(4);
            chk({drive_out_en, motor_power_on}, 2'b00);
         end else begin
            edges(8);
            chk({drive_out_en, motor_power_on}, 2'b11);
            @(posedge pclk);
            en_req <= 1'b0;
            edges(6);
            chk(drive_out_en, 1'b0);
         end
      end
      apb(`SFS_OFF_IRQ_STS, 1'b0, 32'h0);
      chk({irq, rd[4:0]}, {1'b0, m != 0, 4'(1 << c)});
      clear_stop();
   endtask : run_stop

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // ==========================================
   // Clock, watchdog and test sequence
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      // About eighteen times the expected run length
      #(100 * 40000);
      failures++;
      report_and_stop();
   end

   initial begin
      seed = 78163;
      {psel, penable, pwrite, fault_valid, limit_pin} = 5'b0;
      {paddr, pwdata, fault_code} = '0;
      run_speed = 16'h0000;
      en_req = 1'b1;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         apb(8'(offs[i]), 1'b0, 32'h0);
         chk(rd, 32'(rsts[i]));
      end
      apb(8'h2c, 1'b0, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      $display("Test register reset done");
      apb(`SFS_OFF_RATED, 1'b1, 32'd10);
      apb(`SFS_OFF_FAST_TIME, 1'b1, 32'd3);
      apb(`SFS_OFF_SLOW_TIME, 1'b1, 32'd6);
      apb(`SFS_OFF_IRQ_MASK, 1'b1, 32'h1);
      codes[3] = 100 + {$random(seed)} % 100;
      for (int i = 0; i < 4; i++) begin
         pulse(10'(codes[i]));
         wait_stop();
         edges(1);
         chk({stop_active, drive_out_en, motor_power_on}, 3'b100);
         edges(2);
         chk(irq, 1'b1);
         clear_stop();
         chk(irq, 1'b0);
      end
      pulse(10'd99);
      pulse(10'd1000);
      edges(3);
      chk(stop_active, 1'b0);
      $display("Test serious class done");
      for (int c = 1; c < 4; c++)
         for (int m = 0; m < 6; m++)
            run_stop(c, m);
      $display("Test stop modes done");
      apb(`SFS_OFF_MINOR_MODE, 1'b1, 32'd4);
      pulse(10'd700);
      edges(5);
      pulse(10'd150);
      edges(2);
      chk({drive_out_en, motor_power_on}, 2'b00);
      pulse(10'd300);
      edges(3);
      chk({drive_out_en, motor_power_on, brake_on}, 3'b000);
      clear_stop();
      $display("Test severity order done");
      // Mode codes above 5 must fall back to a free coast
      apb(`SFS_OFF_GEN_MODE, 1'b1, 32'd7);
      pulse(10'd400);
      edges(2);
      chk({drive_out_en, motor_power_on}, 2'b00);
      apb(`SFS_OFF_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h0000_011c);
      clear_stop();
      $display("Test fallback mode done");
      report_and_stop();
   end
endmodule : sfs_top_tb_top
